// File: bmwr_host.sv
`timescale 1ns/1ps
`default_nettype none

// Configuration master that stands in for host software on the primary side.
module bmwr_host
(
  // Clock.
  input  wire logic        sys_clk,
  // Configuration access towards the window registers.
  output var  logic        cfg_wr,
  output var  logic        cfg_rd,
  output var  logic [7:0]  cfg_addr,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata
);
  // Quiet bus at time zero.
  initial
  begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // One strobe cycle, launched at the falling edge so the rising edge sees it settled.
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_wr    = w;
    cfg_rd    = r;
    cfg_addr  = a;
    cfg_be    = b;
    cfg_wdata = d;
  endtask : access

  // Released lines show the inverse, so a design that samples them late cannot pass by luck.
  task automatic idle();
    @(negedge sys_clk);
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_be    = 4'h0;
    cfg_addr  = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
  endtask : idle
endmodule : bmwr_host

`default_nettype wire

// File: bmwr_pkg.sv
`default_nettype none

package bmwr_pkg;

  // Which window register a configuration access selects.
  typedef enum logic [2:0] {
    BMWR_SEL_NONE = 3'h0,
    BMWR_SEL_MEM  = 3'h1,
    BMWR_SEL_PREF = 3'h2,
    BMWR_SEL_BHI  = 3'h3,
    BMWR_SEL_THI  = 3'h4
  } bmwr_sel_type;

endpackage : bmwr_pkg

`default_nettype wire

// File: bmwr_regs.svh
`ifndef BMWR_REGS_SVH
`define BMWR_REGS_SVH

// Configuration dword offsets of the window registers.
`define BMWR_OFS_MEM      8'h20
`define BMWR_OFS_PREF     8'h24
`define BMWR_OFS_PREF_BHI 8'h28
`define BMWR_OFS_PREF_THI 8'h2C

// Field positions inside a shared bottom/top dword.
`define BMWR_BOT_LSB 4
`define BMWR_TOP_LSB 20
`define BMWR_CAP_BOT_LSB 0
`define BMWR_CAP_TOP_LSB 16

// Bits that software may change in a shared bottom/top dword.
`define BMWR_WMASK_WIN 32'hFFF0FFF0

// Capability codes of the prefetchable window.
`define BMWR_CAP_32 4'h0
`define BMWR_CAP_64 4'h1

// Implied low address bits of an expanded bottom and top.
`define BMWR_BOT_LO 20'h00000
`define BMWR_TOP_LO 20'hFFFFF

// Reset values.
`define BMWR_RST_FIELD 12'h000
`define BMWR_RST_WORD  32'h00000000

`endif

// File: bmwr_window.sv
// Notes on behaviour
// RULE_01 - Memory window low nibbles read zero, ignore writes.
// RULE_02 - Memory bottom field gives address bits 31:20.
// RULE_03 - Memory top field, low bits all ones.
// RULE_04 - Memory window range decides forwarding.
// RULE_05 - Prefetchable capability nibbles read 64-bit code.
// RULE_06 - Prefetchable bottom field gives bits 31:20.
// RULE_07 - Prefetchable top field, low bits ones.
// RULE_08 - Prefetchable range decides read/write forwarding.
// RULE_09 - Prefetchable bottom high word, writable, resets zero.
// RULE_10 - Prefetchable top high word, writable, resets zero.
// RULE_11 - Inside means bottom <= address <= top.
// RULE_12 - Bottom above top means empty window.
`timescale 1ns/1ps
`default_nettype none
`include "bmwr_regs.svh"

module bmwr_window
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Configuration access from the primary side.
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output var  logic [31:0] cfg_rdata,
  // Address decode request.
  input  wire logic        dec_valid,
  input  wire logic [63:0] dec_addr,
  // Decode answer, one cycle after the request.
  output var  logic        mem_hit,
  output var  logic        pref_hit,
  output var  logic        dec_done
);

  // Stored window fields.
  logic [11:0] mem_bot_q;      // Memory bottom, address 31:20.
  logic [11:0] mem_bot_d;
  logic [11:0] mem_top_q;      // Memory top, address 31:20.
  logic [11:0] mem_top_d;
  logic [11:0] pf_bot_q;       // Prefetchable bottom, 31:20.
  logic [11:0] pf_bot_d;
  logic [11:0] pf_top_q;       // Prefetchable top, 31:20.
  logic [11:0] pf_top_d;
  logic [31:0] pf_bot_hi_q;    // Prefetchable bottom, 63:32.
  logic [31:0] pf_bot_hi_d;
  logic [31:0] pf_top_hi_q;    // Prefetchable top, 63:32.
  logic [31:0] pf_top_hi_d;

  // Answer flops.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        mem_hit_q;
  logic        mem_hit_d;
  logic        pref_hit_q;
  logic        pref_hit_d;
  logic        done_q;
  logic        done_d;

  // Decoded access target and register images.
  bmwr_pkg::bmwr_sel_type sel;
  logic [31:0] mem_img;        // Dword image at the memory offset.
  logic [31:0] pf_img;         // Dword image at the prefetch offset.
  logic [63:0] mem_bot_x;      // Expanded memory bottom.
  logic [63:0] mem_top_x;      // Expanded memory top.
  logic [63:0] pf_bot_x;       // Expanded prefetchable bottom.
  logic [63:0] pf_top_x;       // Expanded prefetchable top.

  // Merges write data into a dword per byte lane, keeping bits
  // outside the writable mask.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wm);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = (wd[i*8 +: 8] & wm[i*8 +: 8]) |
                      (old[i*8 +: 8] & ~wm[i*8 +: 8]);
      end
    end
    return r;
  endfunction : merge

  // Offset decode; the low two address bits select nothing, so they
  // are forced to zero and the full byte offsets compare at one width.
  always_comb
  begin
    case ({cfg_addr[7:2], 2'b00})
      `BMWR_OFS_MEM:      sel = bmwr_pkg::BMWR_SEL_MEM;
      `BMWR_OFS_PREF:     sel = bmwr_pkg::BMWR_SEL_PREF;
      `BMWR_OFS_PREF_BHI: sel = bmwr_pkg::BMWR_SEL_BHI;
      `BMWR_OFS_PREF_THI: sel = bmwr_pkg::BMWR_SEL_THI;
      // Every other offset belongs to another block.
      default:                 sel = bmwr_pkg::BMWR_SEL_NONE;
    endcase
  end

  // Read images; fixed nibbles come from constants, so writes to
  // them can never stick.
  always_comb
  begin
    mem_img = '0;
    mem_img[`BMWR_BOT_LSB +: 12] = mem_bot_q;  // RULE_02
    mem_img[`BMWR_TOP_LSB +: 12] = mem_top_q;  // RULE_03
    pf_img  = '0;
    pf_img[`BMWR_CAP_BOT_LSB +: 4] = `BMWR_CAP_64;  // RULE_05
    pf_img[`BMWR_CAP_TOP_LSB +: 4] = `BMWR_CAP_64;  // RULE_05
    pf_img[`BMWR_BOT_LSB +: 12] = pf_bot_q;  // RULE_06
    pf_img[`BMWR_TOP_LSB +: 12] = pf_top_q;  // RULE_07
  end

  // Expanded window edges: bottoms pad with zeros, tops with ones.
  always_comb
  begin
    mem_bot_x = {32'h00000000, mem_bot_q, `BMWR_BOT_LO};  // RULE_02
    mem_top_x = {32'h00000000, mem_top_q, `BMWR_TOP_LO};  // RULE_03
    pf_bot_x  = {pf_bot_hi_q, pf_bot_q, `BMWR_BOT_LO};  // RULE_06
    pf_top_x  = {pf_top_hi_q, pf_top_q, `BMWR_TOP_LO};  // RULE_07
  end

  // Next values of the window registers. Only the masked field bits
  // of a shared dword take write data.
  always_comb
  begin
    logic [31:0] w;
    w           = '0;
    mem_bot_d   = mem_bot_q;
    mem_top_d   = mem_top_q;
    pf_bot_d    = pf_bot_q;
    pf_top_d    = pf_top_q;
    pf_bot_hi_d = pf_bot_hi_q;
    pf_top_hi_d = pf_top_hi_q;
    if (cfg_wr)
    begin
      case (sel)
        bmwr_pkg::BMWR_SEL_MEM:
        begin
          w = merge(mem_img, cfg_wdata, cfg_be, `BMWR_WMASK_WIN);  // RULE_01
          mem_bot_d = w[`BMWR_BOT_LSB +: 12];  // RULE_02
          mem_top_d = w[`BMWR_TOP_LSB +: 12];  // RULE_03
        end
        bmwr_pkg::BMWR_SEL_PREF:
        begin
          w = merge(pf_img, cfg_wdata, cfg_be, `BMWR_WMASK_WIN);  // RULE_05
          pf_bot_d = w[`BMWR_BOT_LSB +: 12];  // RULE_06
          pf_top_d = w[`BMWR_TOP_LSB +: 12];  // RULE_07
        end
        bmwr_pkg::BMWR_SEL_BHI:
        begin
          pf_bot_hi_d = merge(pf_bot_hi_q, cfg_wdata, cfg_be, '1);  // RULE_09
        end
        bmwr_pkg::BMWR_SEL_THI:
        begin
          pf_top_hi_d = merge(pf_top_hi_q, cfg_wdata, cfg_be, '1);  // RULE_10
        end
        // Writes to other offsets are dropped here.
        default:
        begin
          w = '0;
        end
      endcase
    end
  end

  // Window register flops; all fields clear at reset.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_bot_q   <= `BMWR_RST_FIELD;  // RULE_02
      mem_top_q   <= `BMWR_RST_FIELD;
      pf_bot_q    <= `BMWR_RST_FIELD;
      pf_top_q    <= `BMWR_RST_FIELD;
      pf_bot_hi_q <= `BMWR_RST_WORD;  // RULE_09
      pf_top_hi_q <= `BMWR_RST_WORD;  // RULE_10
    end
    else
    begin
      mem_bot_q   <= mem_bot_d;
      mem_top_q   <= mem_top_d;
      pf_bot_q    <= pf_bot_d;
      pf_top_q    <= pf_top_d;
      pf_bot_hi_q <= pf_bot_hi_d;
      pf_top_hi_q <= pf_top_hi_d;
    end
  end

  // Read data and decode answers. The range tests are plain 64-bit
  // compares, so a bottom above its top matches no address at all;
  // an upper word on a 32-bit access is simply zero.
  always_comb
  begin
    rdata_d = rdata_q;
    if (cfg_rd)
    begin
      case (sel)
        bmwr_pkg::BMWR_SEL_MEM:  rdata_d = mem_img;  // RULE_01
        bmwr_pkg::BMWR_SEL_PREF: rdata_d = pf_img;  // RULE_05
        bmwr_pkg::BMWR_SEL_BHI:  rdata_d = pf_bot_hi_q;
        bmwr_pkg::BMWR_SEL_THI:  rdata_d = pf_top_hi_q;
        // Unmapped offsets read as zero.
        default:                 rdata_d = '0;
      endcase
    end
    done_d     = dec_valid;
    mem_hit_d  = dec_valid && (dec_addr >= mem_bot_x) &&
                 (dec_addr <= mem_top_x);  // RULE_04 RULE_11 RULE_12
    pref_hit_d = dec_valid && (dec_addr >= pf_bot_x) &&
                 (dec_addr <= pf_top_x);  // RULE_08 RULE_11 RULE_12
  end

  // Answer flops; the read word holds until the next read.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q    <= `BMWR_RST_WORD;
      mem_hit_q  <= 1'b0;
      pref_hit_q <= 1'b0;
      done_q     <= 1'b0;
    end
    else
    begin
      rdata_q    <= rdata_d;
      mem_hit_q  <= mem_hit_d;
      pref_hit_q <= pref_hit_d;
      done_q     <= done_d;
    end
  end

  // Outputs come straight from flops.
  assign cfg_rdata = rdata_q;
  assign mem_hit   = mem_hit_q;
  assign pref_hit  = pref_hit_q;
  assign dec_done  = done_q;

  // Checks on the register and decode behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_rd_mem;
    cfg_rd && !cfg_wr && sel == bmwr_pkg::BMWR_SEL_MEM;
  endsequence

  sequence s_rd_pref;
    cfg_rd && !cfg_wr && sel == bmwr_pkg::BMWR_SEL_PREF;
  endsequence

  sequence s_wr_full(bmwr_pkg::bmwr_sel_type s);
    cfg_wr && cfg_be == 4'hF && sel == s;
  endsequence

  property p_mem_low_zero;
    s_rd_mem |=> cfg_rdata[3:0] == 4'h0 && cfg_rdata[19:16] == 4'h0;
  endproperty
  a_mem_low_zero: assert property (p_mem_low_zero) else $error("memory low nibble set"); // RULE_01

  property p_mem_bot_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_MEM) ##1 s_rd_mem
      |=> cfg_rdata[15:4] == $past(cfg_wdata[15:4], 2);
  endproperty
  a_mem_bot_wr: assert property (p_mem_bot_wr) else $error("memory bottom lost"); // RULE_02

  property p_mem_top_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_MEM) |=> mem_top_q == $past(cfg_wdata[31:20]);
  endproperty
  a_mem_top_wr: assert property (p_mem_top_wr) else $error("memory top lost"); // RULE_03

  property p_mem_hit;
    dec_valid |=> mem_hit == ($past(dec_addr[63:32]) == 32'h00000000 &&
      $past(dec_addr[31:20]) >= $past(mem_bot_q) &&
      $past(dec_addr[31:20]) <= $past(mem_top_q));
  endproperty
  a_mem_hit: assert property (p_mem_hit) else $error("memory decode wrong"); // RULE_04

  property p_pref_cap;
    s_rd_pref |=> cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1;
  endproperty
  a_pref_cap: assert property (p_pref_cap) else $error("capability code wrong"); // RULE_05

  property p_pref_bot_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_PREF) |=> pf_bot_q == $past(cfg_wdata[15:4]);
  endproperty
  a_pref_bot_wr: assert property (p_pref_bot_wr) else $error("prefetch bottom lost"); // RULE_06

  property p_pref_top_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_PREF) |=> pf_top_q == $past(cfg_wdata[31:20]);
  endproperty
  a_pref_top_wr: assert property (p_pref_top_wr) else $error("prefetch top lost"); // RULE_07

  property p_pref_hit;
    dec_valid |=> pref_hit == ($past(dec_addr) >= {$past(pf_bot_hi_q),
      $past(pf_bot_q), 20'h00000} && $past(dec_addr) <=
      {$past(pf_top_hi_q), $past(pf_top_q), 20'hFFFFF});
  endproperty
  a_pref_hit: assert property (p_pref_hit) else $error("prefetch decode wrong"); // RULE_08

  property p_bhi_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_BHI) |=> pf_bot_hi_q == $past(cfg_wdata);
  endproperty
  a_bhi_wr: assert property (p_bhi_wr) else $error("bottom high word lost"); // RULE_09

  property p_thi_wr;
    s_wr_full(bmwr_pkg::BMWR_SEL_THI) ##1 cfg_rd && !cfg_wr &&
      sel == bmwr_pkg::BMWR_SEL_THI |=> cfg_rdata == $past(cfg_wdata, 2);
  endproperty
  a_thi_wr: assert property (p_thi_wr) else $error("top high word lost"); // RULE_10

  property p_hit_needs_valid;
    !dec_valid |=> !mem_hit && !pref_hit && !dec_done;
  endproperty
  a_hit_needs_valid: assert property (p_hit_needs_valid) else $error("hit without request"); // RULE_11

  property p_empty;
    dec_valid && {pf_bot_hi_q, pf_bot_q} > {pf_top_hi_q, pf_top_q} |=> !pref_hit;
  endproperty
  a_empty: assert property (p_empty) else $error("empty window hit"); // RULE_12

endmodule : bmwr_window
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmwr_regs.svh"

module tb;
  logic        sys_clk = 1'b0;   // System clock, 200 MHz.
  logic        reset   = 1'b1;   // Asynchronous reset.
  logic        cfg_wr, cfg_rd;   // Strobes from the host model.
  logic [7:0]  cfg_addr;         // Offset from the host model.
  logic [3:0]  cfg_be;           // Byte lanes from the host model.
  logic [31:0] cfg_wdata, cfg_rdata;
  logic        dec_valid = 1'b0; // Decode request.
  logic [63:0] dec_addr  = 64'h0;
  logic        mem_hit, pref_hit, dec_done;
  logic [31:0] r20, r24, r28, r2c; // Shadow copies of the registers.
  logic [31:0] rq[$];            // Expected read data, oldest first.
  logic [1:0]  dq[$];            // Expected hits, oldest first.
  logic        rd_pend = 1'b0;   // A read was taken at the last edge.
  logic        dv_pend = 1'b0;   // A decode was taken at the last edge.
  int          failures = 0;
  int          comparisons = 0;

  always #2.5 sys_clk = ~sys_clk;

  bmwr_host host (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
                  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  bmwr_window uut (.sys_clk(sys_clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
                   .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
                   .cfg_rdata(cfg_rdata), .dec_valid(dec_valid), .dec_addr(dec_addr),
                   .mem_hit(mem_hit), .pref_hit(pref_hit), .dec_done(dec_done));

  // Single comparison point for every result.
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // Software view of a register; capability nibbles always read as 64-bit.
  function automatic logic [31:0] exp_val(input logic [7:0] a);
    case (a)
      `BMWR_OFS_MEM:      exp_val = r20;
      `BMWR_OFS_PREF:     exp_val = r24 | 32'h00010001;
      `BMWR_OFS_PREF_BHI: exp_val = r28;
      `BMWR_OFS_PREF_THI: exp_val = r2c;
      default:            exp_val = 32'h00000000;
    endcase
  endfunction : exp_val

  // Write: the shadow takes enabled, writable bytes only; unmapped offsets change nothing.
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    case (a)
      `BMWR_OFS_MEM:      r20 = (r20 & ~(m & `BMWR_WMASK_WIN)) | (d & m & `BMWR_WMASK_WIN);
      `BMWR_OFS_PREF:     r24 = (r24 & ~(m & `BMWR_WMASK_WIN)) | (d & m & `BMWR_WMASK_WIN);
      `BMWR_OFS_PREF_BHI: r28 = (r28 & ~m) | (d & m);
      `BMWR_OFS_PREF_THI: r2c = (r2c & ~m) | (d & m);
      default:            r20 = r20;
    endcase
    host.access(1'b1, 1'b0, a, b, d);
  endtask : wr

  // Read: the expectation is noted before the strobe goes out.
  task automatic rd(input logic [7:0] a);
    rq.push_back(exp_val(a));
    host.access(1'b0, 1'b1, a, 4'h0, 32'h00000000);
  endtask : rd

  // Decode request; bottom and top are expanded with zeros and ones in the low 20 bits.
  task automatic dec(input logic [63:0] a);
    logic [63:0] mb, mt, pb, pt;
    mb = {32'h0, r20[15:4], 20'h00000};
    mt = {32'h0, r20[31:20], 20'hFFFFF};
    pb = {r28, r24[15:4], 20'h00000};
    pt = {r2c, r24[31:20], 20'hFFFFF};
    dq.push_back({(a >= mb) && (a <= mt), (a >= pb) && (a <= pt)});
    @(negedge sys_clk);
    dec_valid = 1'b1;
    dec_addr  = a;
  endtask : dec

  // Probe both edges of both windows back to back, then a random address.
  task automatic probe();
    dec({32'h0, r20[15:4], 20'h00000} - 64'h1);
    dec({32'h0, r20[15:4], 20'h00000});
    dec({32'h0, r20[31:20], 20'hFFFFF});
    dec({32'h0, r20[31:20], 20'hFFFFF} + 64'h1);
    dec({r28, r24[15:4], 20'h00000} - 64'h1);
    dec({r28, r24[15:4], 20'h00000});
    dec({r2c, r24[31:20], 20'hFFFFF});
    dec({r2c, r24[31:20], 20'hFFFFF} + 64'h1);
    dec({32'($urandom), 32'($urandom)});
    @(negedge sys_clk);
    dec_valid = 1'b0;
    dec_addr  = ~dec_addr;
  endtask : probe

  // Read every mapped offset and one unmapped offset back to back.
  task automatic read_all();
    rd(`BMWR_OFS_MEM);
    rd(`BMWR_OFS_PREF);
    rd(`BMWR_OFS_PREF_BHI);
    rd(`BMWR_OFS_PREF_THI);
    rd(8'h30);
    host.idle();
  endtask : read_all

  // Remember what the design took at each rising edge.
  always @(posedge sys_clk)
  begin
    rd_pend <= cfg_rd & ~reset;
    dv_pend <= dec_valid & ~reset;
  end

  // Results are settled by the falling edge; each is matched to the oldest note.
  always @(negedge sys_clk)
  begin
    if (!reset)
    begin
      if (rd_pend && rq.size() > 0)
        check("cfg_rdata", cfg_rdata, rq.pop_front());
      check("dec_done", {31'h0, dec_done}, {31'h0, dv_pend});
      if (dv_pend && dq.size() > 0)
        check("hits", {30'h0, mem_hit, pref_hit}, {30'h0, dq.pop_front()});
    end
  end

  // Closing report, reached from the end of the main sequence only.
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial
  begin
    void'($urandom(26412));
    {r20, r24, r28, r2c} = 128'h0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    read_all();
    probe();
    // All ones everywhere shows which bits are writable.
    wr(`BMWR_OFS_MEM, 4'hF, 32'hFFFFFFFF);
    wr(`BMWR_OFS_PREF, 4'hF, 32'hFFFFFFFF);
    wr(`BMWR_OFS_PREF_BHI, 4'hF, 32'hFFFFFFFF);
    wr(`BMWR_OFS_PREF_THI, 4'hF, 32'hFFFFFFFF);
    wr(8'h30, 4'hF, 32'hFFFFFFFF);
    read_all();
    probe();
    // A full write read back at once, so the write-then-read checks fire.
    wr(`BMWR_OFS_MEM, 4'hF, 32'h5A5A5A5A);
    rd(`BMWR_OFS_MEM);
    wr(`BMWR_OFS_PREF_THI, 4'hF, $urandom);
    rd(`BMWR_OFS_PREF_THI);
    host.idle();
    probe();
    // Random contents and lanes; bottom above top happens about half the time.
    for (int i = 0; i < 60; i++)
    begin
      wr(8'h20 + 8'(4 * ($urandom % 5)), 4'($urandom), $urandom);
      if (i % 3 == 0)
        read_all();
      host.idle();
      probe();
    end
    // Reset in mid-run returns every field to its reset value.
    @(negedge sys_clk);
    reset = 1'b1;
    {r20, r24, r28, r2c} = 128'h0;
    @(negedge sys_clk);
    reset = 1'b0;
    read_all();
    probe();
    for (int i = 0; i < 10 && (rq.size() > 0 || dq.size() > 0); i++)
      @(negedge sys_clk);
    if (rq.size() > 0 || dq.size() > 0)
      failures++;
    print_verdict();
  end
endmodule : tb

`default_nettype wire
